// File: verilog/dtc_top.sv
// dual timer/counter with wishbone register slave
//
// How it works
// - timer counts once per six-clock machine cycle
// - counter samples pin each cycle, counts falls
// - count appears the machine cycle after detection
// - one fall takes two machine cycles to count
// - mode bit two picks timer or counter
// - gate bit needs irq-zero pin high to count
// - two-bit mode fields: bits 5:4, bits 1:0
// - modes 0-2 shared, mode 3 differs
// - timer 0 overflow may toggle count pin
// - mode 0: 13-bit count, flag on rollover
// - mode 1: full 16-bit count
// - mode 2: low byte reloads from high byte
// - mode 3: split high byte; timer 1 stops
`timescale 1ns/1ns
module dtc_top #(
  parameter int MC_CLOCKS = dtc_pkg::MC_CLOCKS
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [9:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic EXT_IRQ_ZERO_PIN,
  input wire logic EVENT_COUNT_PIN_I,
  output logic EVENT_COUNT_PIN_O,
  output logic EVENT_COUNT_PIN_OE_N,
  output logic IRQ
);

  if (MC_CLOCKS < 2 || MC_CLOCKS > 256) begin : g_bad_mc
    $error("MC_CLOCKS out of range");
  end

  // one step of a timer in the given mode: {overflow, high, low}
  function automatic logic [16:0] count_step(input logic [1:0] mode, input logic [7:0] hi, input logic [7:0] lo);
    logic [12:0] v13;
    logic [15:0] v16;
    v13 = 13'({hi, lo[4:0]} + 13'h0001);
    v16 = 16'({hi, lo} + 16'h0001);
    unique case (dtc_pkg::dtc_mode_t'(mode))
      dtc_pkg::DTC_M13: count_step = {({hi, lo[4:0]} == 13'h1FFF), v13[12:5], lo[7:5], v13[4:0]};
      dtc_pkg::DTC_M16: count_step = {(v16 == 16'h0000), v16};
      dtc_pkg::DTC_MRELOAD: count_step = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, 8'(lo + 8'h01)};
      dtc_pkg::DTC_MSPLIT: count_step = {(lo == 8'hFF), hi, 8'(lo + 8'h01)};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic ack_q;
  logic bus_req;
  logic bus_wr;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic [7:0] rdat;

  assign bus_req = WB_CYC_I & WB_STB_I;
  assign idx = WB_ADR_I[9:2];
  assign wdat = WB_DAT_I[7:0];
  // writes land on the edge where the master sees ack
  assign bus_wr = bus_req & WB_WE_I & ack_q & WB_SEL_I[0];
  assign WB_ACK_O = ack_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [5:0] mode_q;
  logic [3:0] ctrl_q;
  logic [7:0] tl0_q;
  logic [7:0] th0_q;
  logic [7:0] tl1_q;
  logic [7:0] th1_q;
  logic tog_en_q;
  logic tog_q;
  logic [1:0] stat_q;
  logic [1:0] en_q;
  logic [1:0] mode0;
  logic [1:0] mode1;

  assign mode0 = mode_q[dtc_pkg::MODE0_LSB +: 2];
  assign mode1 = mode_q[dtc_pkg::MODE1_LSB +: 2];

  always_comb begin
    rdat = 8'h00;
    unique case (idx)
      dtc_pkg::MODE_IDX: rdat = {2'b00, mode_q};
      dtc_pkg::CTRL_IDX: rdat = {4'h0, ctrl_q};
      dtc_pkg::T0_LOW_IDX: rdat = tl0_q;
      dtc_pkg::T0_HIGH_IDX: rdat = th0_q;
      dtc_pkg::T1_LOW_IDX: rdat = tl1_q;
      dtc_pkg::T1_HIGH_IDX: rdat = th1_q;
      dtc_pkg::TOGGLE_IDX: rdat = {7'h00, tog_en_q};
      dtc_pkg::IRQ_STAT_IDX: rdat = {6'h00, stat_q};
      dtc_pkg::IRQ_EN_IDX: rdat = {6'h00, en_q};
      default: rdat = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      WB_DAT_O <= 32'h00000000;
    end else if (bus_req & ~ack_q) begin
      WB_DAT_O <= {24'h000000, rdat};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle and pin sampling

  logic [7:0] pre_q;
  logic tick;
  logic samp_q;
  logic fall_q;

  assign tick = (pre_q == 8'(MC_CLOCKS - 1));

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= tick ? 8'h00 : 8'(pre_q + 8'h01);
    end
  end

  // a fall is flagged at one sample and used at the next, hence two machine cycles
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      samp_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (tick) begin
      samp_q <= EVENT_COUNT_PIN_I;
      fall_q <= samp_q & ~EVENT_COUNT_PIN_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting

  logic run0;
  logic run1;
  logic en0;
  logic inc0;
  logic inc_h;
  logic inc1;
  logic [16:0] nx0;
  logic [16:0] nx1;
  logic ev_ovf0;
  logic ev_ovf1;
  logic split0;

  assign run0 = ctrl_q[dtc_pkg::RUN0_BIT];
  assign run1 = ctrl_q[dtc_pkg::RUN1_BIT];
  assign split0 = (mode0 == 2'(dtc_pkg::DTC_MSPLIT));
  assign en0 = run0 & (~mode_q[dtc_pkg::GATE_BIT] | EXT_IRQ_ZERO_PIN);
  assign inc0 = en0 & tick & (mode_q[dtc_pkg::CT_BIT] ? fall_q : 1'b1);
  assign inc_h = split0 & tick & run1;
  assign inc1 = tick & run1 & (mode1 != 2'(dtc_pkg::DTC_MSPLIT));
  assign nx0 = count_step(mode0, th0_q, tl0_q);
  assign nx1 = count_step(mode1, th1_q, tl1_q);
  assign ev_ovf0 = inc0 & nx0[16];
  // in split mode the high byte of timer 0 owns the second flag
  assign ev_ovf1 = (inc_h & (th0_q == 8'hFF)) | (inc1 & nx1[16] & ~split0);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tl0_q <= dtc_pkg::COUNT_RESET;
    end else if (bus_wr && idx == dtc_pkg::T0_LOW_IDX) begin
      tl0_q <= wdat;
    end else if (inc0) begin
      tl0_q <= nx0[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      th0_q <= dtc_pkg::COUNT_RESET;
    end else if (bus_wr && idx == dtc_pkg::T0_HIGH_IDX) begin
      th0_q <= wdat;
    end else if (inc_h) begin
      th0_q <= 8'(th0_q + 8'h01);
    end else if (inc0 && !split0) begin
      th0_q <= nx0[15:8];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tl1_q <= dtc_pkg::COUNT_RESET;
      th1_q <= dtc_pkg::COUNT_RESET;
    end else begin
      if (bus_wr && idx == dtc_pkg::T1_LOW_IDX) begin
        tl1_q <= wdat;
      end else if (inc1) begin
        tl1_q <= nx1[7:0];
      end
      if (bus_wr && idx == dtc_pkg::T1_HIGH_IDX) begin
        th1_q <= wdat;
      end else if (inc1) begin
        th1_q <= nx1[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode, control, toggle and interrupt registers

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mode_q <= dtc_pkg::MODE_RESET;
    end else if (bus_wr && idx == dtc_pkg::MODE_IDX) begin
      mode_q <= wdat[5:0];
    end
  end

  // hardware set of an overflow flag wins over a software write
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q <= dtc_pkg::CTRL_RESET;
    end else begin
      if (bus_wr && idx == dtc_pkg::CTRL_IDX) begin
        ctrl_q <= wdat[3:0];
      end
      if (ev_ovf0) begin
        ctrl_q[dtc_pkg::OVF0_BIT] <= 1'b1;
      end
      if (ev_ovf1) begin
        ctrl_q[dtc_pkg::OVF1_BIT] <= 1'b1;
      end
    end
  end

  // pin idles high while the toggle option is off
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tog_en_q <= 1'b0;
      tog_q <= 1'b1;
    end else begin
      if (bus_wr && idx == dtc_pkg::TOGGLE_IDX) begin
        tog_en_q <= wdat[0];
      end
      if (!tog_en_q) begin
        tog_q <= 1'b1;
      end else if (ev_ovf0) begin
        tog_q <= ~tog_q;
      end
    end
  end

  assign EVENT_COUNT_PIN_O = tog_q;
  assign EVENT_COUNT_PIN_OE_N = ~tog_en_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      stat_q <= dtc_pkg::IRQ_RESET;
      en_q <= dtc_pkg::IRQ_RESET;
    end else begin
      stat_q <= (stat_q & ~((bus_wr && idx == dtc_pkg::IRQ_CLR_IDX) ? wdat[1:0] : 2'b00)) | {ev_ovf1, ev_ovf0};
      if (bus_wr && idx == dtc_pkg::IRQ_EN_IDX) begin
        en_q <= wdat[1:0];
      end
    end
  end

  assign IRQ = |(stat_q & en_q);

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_tick_period: assert property (tick |=> !tick [*5] ##1 tick)
    else $error("machine cycle is not six clocks");
  a_fall_seen: assert property (tick && samp_q && !EVENT_COUNT_PIN_I |=> fall_q)
    else $error("falling sample not flagged");
  a_count_lag: assert property (tick && fall_q && en0 && mode_q[2] && mode0 == 2'b01 && !bus_wr
    |=> tl0_q == 8'($past(tl0_q) + 8'h01))
    else $error("counter did not step after a fall");
  a_no_early: assert property (tick && !fall_q && mode_q[2] && !bus_wr |=> $stable(tl0_q))
    else $error("counter stepped without a detected fall");
  a_gate_hold: assert property (mode_q[3] && !EXT_IRQ_ZERO_PIN && !split0 && !bus_wr |=> $stable({th0_q, tl0_q}))
    else $error("gated timer counted with pin low");
  a_t1_step: assert property (inc1 && mode1 == 2'b01 && !bus_wr
    |=> {th1_q, tl1_q} == 16'($past({th1_q, tl1_q}) + 16'h0001))
    else $error("timer 1 16-bit step wrong");
  a_m13_ovf: assert property (inc0 && mode0 == 2'b00 && {th0_q, tl0_q[4:0]} == 13'h1FFF && !bus_wr
    |=> ctrl_q[2] && th0_q == 8'h00 && stat_q[0])
    else $error("13-bit rollover missed");
  a_m2_reload: assert property (inc0 && mode0 == 2'b10 && tl0_q == 8'hFF && !bus_wr
    |=> tl0_q == $past(th0_q) && $stable(th0_q) && ctrl_q[2])
    else $error("auto reload wrong");
  a_t1_stop: assert property (mode1 == 2'b11 && !bus_wr |=> $stable({th1_q, tl1_q}))
    else $error("timer 1 counts in mode 3");
  a_pin_toggle: assert property (ev_ovf0 && tog_en_q && !bus_wr |=> EVENT_COUNT_PIN_O != $past(EVENT_COUNT_PIN_O))
    else $error("pin did not toggle on overflow");

  c_counter_step: cover property (inc0 && mode_q[2]);
  c_reload: cover property (ev_ovf0 && mode0 == 2'b10);
  c_split_ovf: cover property (inc_h && th0_q == 8'hFF);
  c_irq: cover property (IRQ);

endmodule // dtc_top

// File: verilog/dtc_pkg.sv
// constants for the dual timer/counter block
package dtc_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] MODE_IDX = 8'h89;
  localparam logic [7:0] CTRL_IDX = 8'h90;
  localparam logic [7:0] T0_LOW_IDX = 8'h91;
  localparam logic [7:0] T0_HIGH_IDX = 8'h92;
  localparam logic [7:0] T1_LOW_IDX = 8'h93;
  localparam logic [7:0] T1_HIGH_IDX = 8'h94;
  localparam logic [7:0] TOGGLE_IDX = 8'h95;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h96;
  localparam logic [7:0] IRQ_CLR_IDX = 8'h97;
  localparam logic [7:0] IRQ_EN_IDX = 8'h98;
  // timer_mode_control fields
  localparam int MODE0_LSB = 0;
  localparam int CT_BIT = 2;
  localparam int GATE_BIT = 3;
  localparam int MODE1_LSB = 4;
  localparam logic [5:0] MODE_RESET = 6'h00;
  // control register fields
  localparam int RUN0_BIT = 0;
  localparam int RUN1_BIT = 1;
  localparam int OVF0_BIT = 2;
  localparam int OVF1_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // interrupt status bits
  localparam int EV_OVF0 = 0;
  localparam int EV_OVF1 = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // cpu clocks per machine cycle
  localparam int MC_CLOCKS = 6;
  // timer modes
  typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_MRELOAD, DTC_MSPLIT} dtc_mode_t;
endpackage

// File: test/dtc_pin_model.sv
// pin-side model: count pin events and the irq-zero gate level
`timescale 1ns/1ns
module dtc_pin_model #(
  parameter int HOLD = 6
) (
  input wire logic clk,
  input wire logic [7:0] n_falls,
  input wire logic go,
  input wire logic gate_lvl,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic pin_i,
  output logic gate,
  output logic busy
);
  logic lvl_q = 1'h1;
  logic [8:0] left_q = 9'h000;
  int cnt_q = 0;
  ////////////////////////////////////////////////////////////
  // each level stands one full machine cycle, so no sample misses it
  always_ff @(posedge clk) begin
    if (go) begin
      left_q <= {n_falls, 1'h0};
      cnt_q <= 0;
    end else if (left_q != 9'h000) begin
      cnt_q <= (cnt_q == HOLD - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HOLD - 1) begin
        lvl_q <= ~lvl_q;
        left_q <= left_q - 9'h001;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // shared pin: a driving device can only pull the line low
  assign pin_i = pin_oe_n ? lvl_q : (lvl_q & pin_o);
  assign gate = gate_lvl;
  assign busy = (left_q != 9'h000);
endmodule // dtc_pin_model

// File: test/tb_top.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dw = 32'h00000000;
  logic [31:0] dr;
  logic ack, pin_i, pin_o, oe_n, gate, irq, busy;
  logic go = 1'h0;
  logic glvl = 1'h1;
  logic [7:0] nf = 8'h00;
  logic [7:0] v, u;
  int n_errors = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  dtc_top dut_u (.CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .EXT_IRQ_ZERO_PIN(gate),
    .EVENT_COUNT_PIN_I(pin_i), .EVENT_COUNT_PIN_O(pin_o), .EVENT_COUNT_PIN_OE_N(oe_n), .IRQ(irq));
  dtc_pin_model pm_u (.clk(clk), .n_falls(nf), .go(go), .gate_lvl(glvl), .pin_o(pin_o),
    .pin_oe_n(oe_n), .pin_i(pin_i), .gate(gate), .busy(busy));
  ////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= 4'h1;
    adr <= {idx, 2'h0};
    dw <= {24'h000000, d};
    // no cycle count is assumed here; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    v = dr[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  // count settles at most two machine cycles after the last fall
  task automatic falls(input logic [7:0] n);
    @(posedge clk);
    nf <= n;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    @(posedge clk);
    while (busy === 1'h1) begin
      @(posedge clk);
    end
    repeat (14) @(posedge clk);
  endtask
  task automatic test_done;
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    test_done();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    bus(1'h0, dtc_pkg::MODE_IDX, 8'h00);
    `CHK(v, 8'h00);
    bus(1'h0, 8'h20, 8'h00);
    `CHK(v, 8'h00);
    bus(1'h1, dtc_pkg::MODE_IDX, 8'hFF);
    bus(1'h0, dtc_pkg::MODE_IDX, 8'h00);
    `CHK(v, 8'h3F);
    bus(1'h1, dtc_pkg::MODE_IDX, 8'h01);
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h01);
    repeat (60) @(posedge clk);
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h00);
    bus(1'h0, dtc_pkg::T0_LOW_IDX, 8'h00);
    `CHK(v inside {8'h0A, 8'h0B}, 1'h1);
    // 13-bit rollover, interrupt masked first, then enabled and cleared
    bus(1'h1, dtc_pkg::MODE_IDX, 8'h00);
    bus(1'h1, dtc_pkg::T0_HIGH_IDX, 8'hFF);
    bus(1'h1, dtc_pkg::T0_LOW_IDX, 8'h1F);
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h01);
    repeat (8) @(posedge clk);
    `CHK(irq, 1'h0);
    bus(1'h1, dtc_pkg::IRQ_EN_IDX, 8'h01);
    @(posedge clk);
    `CHK(irq, 1'h1);
    bus(1'h0, dtc_pkg::T0_HIGH_IDX, 8'h00);
    `CHK(v, 8'h00);
    bus(1'h0, dtc_pkg::CTRL_IDX, 8'h00);
    `CHK(v[2], 1'h1);
    bus(1'h1, dtc_pkg::IRQ_CLR_IDX, 8'h01);
    @(posedge clk);
    `CHK(irq, 1'h0);
    // reload mode
    bus(1'h1, dtc_pkg::MODE_IDX, 8'h02);
    bus(1'h1, dtc_pkg::T0_HIGH_IDX, 8'hA0);
    bus(1'h1, dtc_pkg::T0_LOW_IDX, 8'hFE);
    repeat (18) @(posedge clk);
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h00);
    bus(1'h0, dtc_pkg::T0_LOW_IDX, 8'h00);
    `CHK(v[7:4], 4'hA);
    bus(1'h0, dtc_pkg::T0_HIGH_IDX, 8'h00);
    `CHK(v, 8'hA0);
    // event counting, then gated by the irq-zero pin
    bus(1'h1, dtc_pkg::MODE_IDX, 8'h05);
    bus(1'h1, dtc_pkg::T0_LOW_IDX, 8'h00);
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h01);
    falls(8'h03);
    bus(1'h0, dtc_pkg::T0_LOW_IDX, 8'h00);
    `CHK(v, 8'h03);
    bus(1'h1, dtc_pkg::MODE_IDX, 8'h0D);
    glvl <= 1'h0;
    falls(8'h02);
    bus(1'h0, dtc_pkg::T0_LOW_IDX, 8'h00);
    `CHK(v, 8'h03);
    glvl <= 1'h1;
    falls(8'h02);
    bus(1'h0, dtc_pkg::T0_LOW_IDX, 8'h00);
    `CHK(v, 8'h05);
    // second timer runs on its own run bit, stops in mode three
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h02);
    repeat (30) @(posedge clk);
    bus(1'h1, dtc_pkg::MODE_IDX, 8'h30);
    bus(1'h0, dtc_pkg::T1_LOW_IDX, 8'h00);
    `CHK(v != 8'h00, 1'h1);
    u = v;
    repeat (30) @(posedge clk);
    bus(1'h0, dtc_pkg::T1_LOW_IDX, 8'h00);
    `CHK(v, u);
    // overflow toggle output
    bus(1'h1, dtc_pkg::MODE_IDX, 8'h01);
    bus(1'h1, dtc_pkg::T0_HIGH_IDX, 8'hFF);
    bus(1'h1, dtc_pkg::T0_LOW_IDX, 8'hFF);
    bus(1'h1, dtc_pkg::TOGGLE_IDX, 8'h01);
    @(posedge clk);
    `CHK({oe_n, pin_o}, 2'h1);
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h01);
    repeat (8) @(posedge clk);
    `CHK({oe_n, pin_o}, 2'h0);
    // split mode: high byte of timer 0 runs on the second run bit, timer 1 keeps counting in 16-bit
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h00);
    bus(1'h1, dtc_pkg::IRQ_CLR_IDX, 8'h03);
    bus(1'h1, dtc_pkg::MODE_IDX, 8'h13);
    bus(1'h1, dtc_pkg::T0_HIGH_IDX, 8'hFE);
    bus(1'h1, dtc_pkg::T0_LOW_IDX, 8'h00);
    bus(1'h1, dtc_pkg::CTRL_IDX, 8'h02);
    repeat (14) @(posedge clk);
    bus(1'h0, dtc_pkg::CTRL_IDX, 8'h00);
    `CHK(v, 8'h0A);
    bus(1'h0, dtc_pkg::T0_LOW_IDX, 8'h00);
    `CHK(v, 8'h00);
    bus(1'h0, dtc_pkg::IRQ_STAT_IDX, 8'h00);
    `CHK(v, 8'h02);
    test_done();
  end
endmodule // tb_top
